/* File: design/gpio_pkg.sv */
package gpio_pkg;

   localparam int unsigned pin_count = 6;
   localparam int unsigned addr_width = 8;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [addr_width-1:0] data_offset = 8'h00;
   localparam logic [addr_width-1:0] direction_offset = 8'h04;
   localparam logic [addr_width-1:0] pullup_offset = 8'h08;
   localparam logic [addr_width-1:0] config_offset = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned wakeup_bit = 6;
   localparam int unsigned clock_out_bit = 7;
   localparam int unsigned input_only_pin = 2;
   localparam int unsigned shared_clock_pin = 4;
   localparam int unsigned osc_select_lsb = 0;
   localparam int unsigned irq_enable_bit = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [pin_count-1:0] direction_reset = 6'h00;
   localparam logic [pin_count-1:0] pullup_reset = 6'h00;
   localparam logic clock_out_reset = 1'b0;
   localparam logic irq_enable_reset = 1'b0;

   typedef enum logic [1:0] {
      osc_internal = 2'h0,
      osc_external = 2'h1,
      osc_rc = 2'h2,
      osc_crystal = 2'h3
   } osc_mode_type;

   localparam osc_mode_type osc_reset = osc_internal;

endpackage : gpio_pkg

/* File: design/sync_if.sv */
interface sync_if #(
   parameter int unsigned width = 7
) (
   input wire logic ref_clk
);
   logic [width-1:0] raw;
   logic [width-1:0] level;

   modport owner (input level, output raw);
   modport filter (input ref_clk, input raw, output level);
endinterface : sync_if

/* File: design/pin_sync.sv */
module pin_sync #(
   parameter int unsigned width = 7
) (
   sync_if.filter sig,
   input wire logic reset_n
);
   logic [width-1:0] first_q;
   logic [width-1:0] second_q;
   logic [width-1:0] third_q;
   logic [width-1:0] level_q;

   // ----------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge sig.ref_clk) begin
      first_q <= sig.raw;
      second_q <= first_q;
      third_q <= second_q;
   end

   always_ff @(posedge sig.ref_clk) begin
      if (!reset_n) begin
         level_q <= '0;
      end else begin
         for (int i = 0; i < int'(width); i++) begin
            if (second_q[i] == third_q[i]) begin
               level_q[i] <= third_q[i];
            end
         end
      end
   end

   assign sig.level = level_q;

endmodule : pin_sync

/* File: design/port_a_gpio.sv */
// Decided for this implementation: the APB interface to the registers.
module port_a_gpio (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpio_pkg::addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [gpio_pkg::pin_count-1:0] pin_in,
   output logic [gpio_pkg::pin_count-1:0] pin_out,
   output logic [gpio_pkg::pin_count-1:0] pin_oe,
   output logic [gpio_pkg::pin_count-1:0] pin_pullup,
   input wire logic undivided_oscillator_clock,
   input wire logic wakeup_request_flag,
   output logic amplifier_output_pin
);
   import gpio_pkg::*;

   localparam int unsigned sync_width = pin_count + 1;
   localparam logic [pin_count-1:0] input_only_mask = pin_count'(1) << input_only_pin;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [pin_count-1:0] port_a_data_latch_q;
   logic [pin_count-1:0] port_a_direction_q;
   logic [pin_count-1:0] port_a_pullup_enable_q;
   logic clock_out_pin_enable_q;
   osc_mode_type oscillator_source_select_q;
   logic irq_enable_q;

   logic [31:0] prdata_q;
   logic [31:0] read_d;
   logic pready_q;
   logic pslverr_q;
   logic mapped;
   logic setup_phase;
   logic write_now;
   logic [pin_count-1:0] pin_level;
   logic osc_level;
   logic [pin_count-1:0] pin_view;
   logic clock_on_pin;
   logic pin4_taken;
   logic [pin_count-1:0] out_d;
   logic [pin_count-1:0] oe_d;
   logic [pin_count-1:0] pull_d;
   logic [pin_count-1:0] out_q;
   logic [pin_count-1:0] oe_q;
   logic [pin_count-1:0] pull_q;
   logic amp_q;
   logic latch_known_q;

   // ----------------------------------------------------------------
   // Pin and oscillator clock synchronisation
   // ----------------------------------------------------------------
   sync_if #(.width(sync_width)) pins (.ref_clk(ref_clk));

   assign pins.raw = {undivided_oscillator_clock, pin_in};
   assign pin_level = pins.level[pin_count-1:0];
   assign osc_level = pins.level[pin_count];

   pin_sync #(.width(sync_width)) u_sync (
      .sig(pins),
      .reset_n(reset_n)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign write_now = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];

   always_comb begin
      mapped = (paddr == data_offset) || (paddr == direction_offset) ||
               (paddr == pullup_offset) || (paddr == config_offset);
   end

   // ----------------------------------------------------------------
   // Pin 4 ownership
   // ----------------------------------------------------------------
   // Clock-out only counts in internal and RC modes
   assign clock_on_pin = clock_out_pin_enable_q &&
                         (oscillator_source_select_q == osc_internal ||
                          oscillator_source_select_q == osc_rc);
   assign pin4_taken = (oscillator_source_select_q == osc_crystal);

   // ----------------------------------------------------------------
   // Read view of the data register
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < int'(pin_count); i++) begin
         pin_view[i] = port_a_direction_q[i] ? port_a_data_latch_q[i] : pin_level[i];
      end
      if (irq_enable_q) begin
         pin_view[input_only_pin] = 1'b0;
      end else begin
         pin_view[input_only_pin] = pin_level[input_only_pin];
      end
   end

   always_comb begin
      read_d = '0;
      case (paddr)
         data_offset: begin
            read_d[pin_count-1:0] = pin_view;
            read_d[wakeup_bit] = wakeup_request_flag;
         end
         direction_offset: begin
            read_d[pin_count-1:0] = port_a_direction_q;
         end
         pullup_offset: begin
            read_d[pin_count-1:0] = port_a_pullup_enable_q;
            read_d[clock_out_bit] = clock_out_pin_enable_q;
         end
         config_offset: begin
            read_d[osc_select_lsb +: 2] = oscillator_source_select_q;
            read_d[irq_enable_bit] = irq_enable_q;
         end
         default: begin
            read_d = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer: read data captured in setup, ready in the first access cycle
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase && !mapped;
         if (setup_phase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : read_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data latch: deliberately without reset so software state survives
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (write_now && paddr == data_offset) begin
         port_a_data_latch_q <= pwdata[pin_count-1:0];
      end
   end

   // Never reset, like the latch: checks on latch contents wait for a first write
   always_ff @(posedge ref_clk) begin
      if (write_now && paddr == data_offset) begin
         latch_known_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         port_a_direction_q <= direction_reset;
      end else if (write_now && paddr == direction_offset) begin
         port_a_direction_q <= pwdata[pin_count-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         port_a_pullup_enable_q <= pullup_reset;
         clock_out_pin_enable_q <= clock_out_reset;
      end else if (write_now && paddr == pullup_offset) begin
         port_a_pullup_enable_q <= pwdata[pin_count-1:0];
         clock_out_pin_enable_q <= pwdata[clock_out_bit];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         oscillator_source_select_q <= osc_reset;
         irq_enable_q <= irq_enable_reset;
      end else if (write_now && paddr == config_offset) begin
         oscillator_source_select_q <= osc_mode_type'(pwdata[osc_select_lsb +: 2]);
         irq_enable_q <= pwdata[irq_enable_bit];
      end
   end

   // ----------------------------------------------------------------
   // Pad control
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < int'(pin_count); i++) begin
         oe_d[i] = port_a_direction_q[i];
         out_d[i] = port_a_data_latch_q[i] & port_a_direction_q[i];
         pull_d[i] = port_a_pullup_enable_q[i] & ~port_a_direction_q[i];
      end
      oe_d[input_only_pin] = 1'b0;
      out_d[input_only_pin] = 1'b0;
      pull_d[input_only_pin] = port_a_pullup_enable_q[input_only_pin];
      if (pin4_taken) begin
         oe_d[shared_clock_pin] = 1'b0;
         out_d[shared_clock_pin] = 1'b0;
         pull_d[shared_clock_pin] = 1'b0;
      end else if (clock_on_pin) begin
         oe_d[shared_clock_pin] = 1'b1;
         out_d[shared_clock_pin] = osc_level;
         pull_d[shared_clock_pin] = 1'b0;
      end
   end

   // The forwarded clock is resampled, so only clocks well below ref_clk/2 survive
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         oe_q <= '0;
         out_q <= '0;
         pull_q <= '0;
         amp_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
         out_q <= out_d;
         pull_q <= pull_d;
         amp_q <= pin4_taken;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign pin_pullup = pull_q;
   assign amplifier_output_pin = amp_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   input_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !pin_oe[input_only_pin])
      else $error("input only pin is driven");

   dir_reset_a: assert property (@(posedge ref_clk)
      !reset_n |=> port_a_direction_q == direction_reset)
      else $error("direction not cleared by reset");

   latch_hold_a: assert property (@(posedge ref_clk)
      (!reset_n && latch_known_q) |=> port_a_data_latch_q == $past(port_a_data_latch_q))
      else $error("reset disturbed data latch");

   oe_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!pin4_taken && !clock_on_pin) |=>
      pin_oe[shared_clock_pin] == $past(port_a_direction_q[shared_clock_pin]))
      else $error("driver does not follow direction");

   pullup_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      port_a_direction_q[0] |=> !pin_pullup[0])
      else $error("pullup on while output");

   pullup_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (port_a_pullup_enable_q[1] && !port_a_direction_q[1]) |=> pin_pullup[1])
      else $error("pullup missing on input");

   irq_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == data_offset && irq_enable_q) |=>
      !prdata[input_only_pin])
      else $error("bit 2 not zero with interrupt on");

   level_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == data_offset && !irq_enable_q) |=>
      prdata[input_only_pin] == $past(pin_level[input_only_pin]))
      else $error("bit 2 not pin level");

   latch_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == data_offset && port_a_direction_q[0]) |=>
      prdata[0] == $past(port_a_data_latch_q[0]))
      else $error("output pin reads wrong");

   wakeup_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == data_offset) |=>
      prdata[wakeup_bit] == $past(wakeup_request_flag))
      else $error("wakeup flag not reflected");

   latch_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (write_now && paddr == data_offset) |=>
      port_a_data_latch_q == $past(pwdata[pin_count-1:0]))
      else $error("latch write lost");

   no_seventh_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == direction_offset) |=> prdata[31:pin_count] == '0)
      else $error("phantom direction bit");

   clock_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clock_on_pin |=> pin_oe[shared_clock_pin])
      else $error("clock out not driven");

   clock_ignored_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      oscillator_source_select_q == osc_external |=>
      pin_oe[shared_clock_pin] == $past(port_a_direction_q[shared_clock_pin]))
      else $error("clock out active in external mode");

   crystal_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pin4_taken |=> !pin_oe[shared_clock_pin] && amplifier_output_pin)
      else $error("pin 4 not released to crystal");

   apb_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      setup_phase |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");

   refused_access_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !mapped) |=> pready && pslverr && prdata == '0)
      else $error("unmapped access not refused");

   strobe_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (psel && penable && pready && pwrite && !pstrb[0]) |=>
      $stable({port_a_direction_q, port_a_pullup_enable_q, clock_out_pin_enable_q, irq_enable_q}))
      else $error("write without strobe changed a register");

   pullup_all_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      port_a_direction_q != '0 |=>
      (pin_pullup & $past(port_a_direction_q) & ~input_only_mask) == '0)
      else $error("pullup left on an output");

   out_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (latch_known_q && !pin4_taken && !clock_on_pin) |=>
      pin_out == ($past(port_a_data_latch_q) & $past(port_a_direction_q) & ~input_only_mask))
      else $error("pin output not from latch");

   pullup_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (setup_phase && !pwrite && paddr == pullup_offset) |=>
      {prdata[31:clock_out_bit + 1], prdata[pin_count]} == '0)
      else $error("phantom pullup bit");

   amp_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !pin4_taken |=> !amplifier_output_pin)
      else $error("amplifier pin claimed outside crystal mode");

   clock_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clock_on_pin |=>
      pin_out[shared_clock_pin] == $past(osc_level) && !pin_pullup[shared_clock_pin])
      else $error("pin 4 not carrying the clock");

   dir_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (write_now && paddr == direction_offset) |=>
      port_a_direction_q == $past(pwdata[pin_count-1:0]))
      else $error("direction write lost");

   config_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (write_now && paddr == config_offset) |=>
      oscillator_source_select_q == $past(pwdata[osc_select_lsb +: 2]))
      else $error("oscillator select write lost");

endmodule : port_a_gpio

/* File: tb/test_port_a_gpio.sv */
module test_port_a_gpio;
   timeunit 1ns;
   timeprecision 1ps;
   import gpio_pkg::*;

   logic ref_clk;
   logic reset_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [addr_width-1:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [pin_count-1:0] pin_in;
   logic [pin_count-1:0] pin_out;
   logic [pin_count-1:0] pin_oe;
   logic [pin_count-1:0] pin_pullup;
   logic undivided_oscillator_clock;
   logic wakeup_request_flag;
   logic amplifier_output_pin;
   logic [31:0] rdata;
   logic rerr;
   int n_mismatch = 0;
   int compares = 0;

   port_a_gpio uut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .pin_pullup(pin_pullup),
      .undivided_oscillator_clock(undivided_oscillator_clock),
      .wakeup_request_flag(wakeup_request_flag),
      .amplifier_output_pin(amplifier_output_pin)
   );

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   // Every transfer starts on a fresh edge, so a release never meets a new request in one step
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic [3:0] st);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, {24'h0, d}, 4'hf);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0, 4'hf);
      check(rdata, exp);
   endtask : rd

   // Pin outputs are looked at mid-cycle, clear of the edge that moves them
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   task automatic set_pins(input logic [5:0] v);
      @(posedge ref_clk);
      pin_in <= v;
      settle(6);
   endtask : set_pins

   task automatic do_reset;
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
   endtask : do_reset

   task automatic end_of_test;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      pin_in = 6'h00;
      undivided_oscillator_clock = 1'b0;
      wakeup_request_flag = 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(direction_offset, 32'h0);
      rd(pullup_offset, 32'h0);
      rd(config_offset, 32'h0);
      settle(0);
      check(pin_oe, 6'h00);
      wr(direction_offset, 8'hff);
      rd(direction_offset, 32'h3f);
      wr(pullup_offset, 8'h7f);
      rd(pullup_offset, 32'h3f);
      wr(pullup_offset, 8'h80);
      rd(pullup_offset, 32'h80);
      wr(config_offset, 8'h07);
      rd(config_offset, 32'h07);
      wr(config_offset, 8'h00);
      wr(pullup_offset, 8'h00);
      wr(direction_offset, 8'h00);
      set_pins(6'h3f);
      rd(data_offset, 32'h3f);
      wr(config_offset, 8'h04);
      rd(data_offset, 32'h3b);
      wr(config_offset, 8'h00);
      set_pins(6'h1b);
      rd(data_offset, 32'h1b);
      wr(data_offset, 8'h35);
      rd(data_offset, 32'h1b);
      settle(0);
      check(pin_oe, 6'h00);
      wr(direction_offset, 8'h3f);
      settle(1);
      check(pin_oe, 6'h3b);
      check(pin_out & 6'h3b, 6'h31);
      rd(data_offset, 32'h31);
      wr(pullup_offset, 8'h3f);
      settle(1);
      check(pin_pullup, 6'h04);
      wr(direction_offset, 8'h00);
      settle(1);
      check(pin_pullup, 6'h3f);
      wr(pullup_offset, 8'h00);
      settle(1);
      check(pin_pullup, 6'h00);
      // Latch contents must outlive a reset while the direction bits do not
      wr(direction_offset, 8'h3f);
      do_reset;
      rd(direction_offset, 32'h0);
      settle(0);
      check(pin_oe, 6'h00);
      wr(direction_offset, 8'h3f);
      rd(data_offset, 32'h31);
      wr(direction_offset, 8'h00);
      @(posedge ref_clk);
      wakeup_request_flag <= 1'b1;
      rd(data_offset, 32'h5b);
      wr(data_offset, 8'h00);
      rd(data_offset, 32'h5b);
      @(posedge ref_clk);
      wakeup_request_flag <= 1'b0;
      rd(data_offset, 32'h1b);
      xfer(8'h10, 1'b0, 32'h0, 4'hf);
      check({31'h0, rerr}, 32'h1);
      check(rdata, 32'h0);
      xfer(direction_offset, 1'b1, 32'hff, 4'h0);
      check({31'h0, rerr}, 32'h0);
      rd(direction_offset, 32'h0);
      // Every oscillator mode with clock-out on, pin 4 an output driving 0
      wr(direction_offset, 8'h10);
      wr(pullup_offset, 8'h90);
      for (int m = 0; m < 4; m++) begin
         wr(config_offset, m[7:0]);
         for (int k = 1; k >= 0; k--) begin
            @(posedge ref_clk);
            undivided_oscillator_clock <= k[0];
            settle(6);
            check({amplifier_output_pin, pin_pullup[4], pin_oe[4], (m == 3) ? 1'b0 : pin_out[4]},
                  {m == 3, 1'b0, m != 3, (m == 0 || m == 2) && k == 1});
         end
      end
      wr(config_offset, 8'h00);
      wr(pullup_offset, 8'h10);
      wr(direction_offset, 8'h00);
      settle(1);
      check({pin_oe[4], pin_pullup[4]}, 2'b01);
      end_of_test;
   end

endmodule : test_port_a_gpio
